// [rtl/fcs_pkg.sv]
// Package for the flash checksum scanner: register map, fields, reset values, timing.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package fcs_pkg;
    localparam logic [11:0] FCS_OFF_CONTROL_A_REGISTER  = 12'h000;
    localparam logic [11:0] FCS_OFF_CONTROL_B_REGISTER  = 12'h004;
    localparam logic [11:0] FCS_OFF_STATUS = 12'h008;
    localparam logic [11:0] FCS_OFF_DBGST  = 12'h00c;
    localparam int FCS_BIT_RESET  = 7;
    localparam int FCS_BIT_FATAL_IRQ_ON_FAIL_ENABLE  = 1;
    localparam int FCS_BIT_ENABLE = 0;
    localparam int FCS_BIT_OK     = 1;
    localparam int FCS_BIT_BUSY   = 0;
    localparam int FCS_MODE_LSB   = 4;
    localparam int FCS_SRC_LSB    = 0;
    localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
    localparam logic [15:0] FCS_CRC_INIT = 16'hffff;
    localparam logic [7:0]  FCS_CONTROL_A_REGISTER_RST = 8'h00;
    localparam logic [7:0]  FCS_CONTROL_B_REGISTER_RST = 8'h00;
    localparam logic [1:0]  FCS_SRC_BOOTAPP = 2'h0;
    localparam logic [1:0]  FCS_SRC_BOOT    = 2'h1;
    localparam logic [1:0]  FCS_SRC_FULL    = 2'h2;
    localparam int FCS_START_DELAY = 3;
    localparam int FCS_FETCH_PERIOD = 3;
    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } fcs_fetch_t;
    typedef enum logic [3:0] {
        FCS_IDLE  = 4'b0001,
        FCS_START = 4'b0010,
        FCS_FETCH = 4'b0100,
        FCS_CRC   = 4'b1000
    } fcs_state_t;
endpackage

// [rtl/fcs_scanner.sv]
// Flash checksum scanner: CRC-16 over a flash section, APB registers, debug controls.
// Assumes flash answers a word read the cycle after the request; debug inputs are synchronous.
`timescale 1ns/10ps
module fcs_scanner
    import fcs_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          pdebug,
    input  wire logic          dbg_hold,
    input  wire logic          dbg_reg_access,
    input  wire logic          dbg_disconnect,
    input  wire logic          sleeping,
    input  wire logic [AW-1:0] boot_end,
    input  wire logic [AW-1:0] app_end,
    input  wire logic [AW-1:0] flash_end,
    output logic               flash_req,
    output logic [AW-1:0]      flash_addr,
    input  wire logic [15:0]   flash_rdata,
    output logic               cpu_stall,
    output logic               nmi,
    output logic [1:0]         dbg_status
);
    initial begin
        if (AW < 4 || AW > 16) $error("AW out of range");
    end

    fcs_state_t  state_ff, nxt_state;
    logic        ena_ff, fatal_irq_on_fail_enable_ff, busy_ff, ok_ff, nmi_ff, pend_ff, abandon_ff;
    logic [1:0]  src_ff, mode_ff;
    logic [1:0]  dly_ff;
    logic [1:0]  ph_ff;
    logic [15:0] crc_ff;
    logic [AW-1:0] addr_ff;
    logic [15:0] word_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff, stall_ff, freq_ff;
    logic [1:0]  dbgst_ff;

    // CRC of one byte, bit 7 first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ((r << 1) ^ FCS_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    wire         acc     = psel && penable;
    wire         wr      = acc && pwrite && pstrb[0] && !nmi_ff;
    wire         wr_a    = wr && paddr == FCS_OFF_CONTROL_A_REGISTER;
    wire         wr_b    = wr && paddr == FCS_OFF_CONTROL_B_REGISTER && !busy_ff;
    wire         wr_s    = wr && paddr == FCS_OFF_STATUS && pdebug;
    wire         mapped  = paddr == FCS_OFF_CONTROL_A_REGISTER || paddr == FCS_OFF_CONTROL_B_REGISTER ||
                           paddr == FCS_OFF_STATUS || paddr == FCS_OFF_DBGST;
    wire         soft_rst = wr_a && pwdata[FCS_BIT_RESET] && (!fatal_irq_on_fail_enable_ff || !busy_ff);
    wire         go_en   = wr_a && pwdata[FCS_BIT_ENABLE] && !busy_ff;
    wire         go_dbg  = wr_s && pwdata[FCS_BIT_BUSY];
    wire         stop_dbg = wr_s && !pwdata[FCS_BIT_BUSY] && busy_ff;
    // Scanner runs only when neither the debugger nor sleep holds it
    wire         run     = !dbg_hold && !sleeping;
    wire         restart = dbg_reg_access || dbg_disconnect;
    wire [AW-1:0] sec_end = (src_ff == FCS_SRC_BOOT) ? boot_end :
                            (src_ff == FCS_SRC_FULL) ? flash_end : app_end;
    // Section end is exclusive and word addresses are even, so the last word sits at end-2
    wire         last_w  = addr_ff == sec_end - AW'(2);
    wire [15:0]  crc_nx  = crc_byte(crc_byte(crc_ff, word_ff[15:8]), word_ff[7:0]);
    // Checksum bytes run through the CRC leave zero residue on a match
    wire         pass    = crc_nx == 16'h0000;
    wire         fire_fail = state_ff == FCS_CRC && run && last_w && !pass;
    wire         fire_ok0 = wr_s && !pwdata[FCS_BIT_OK];
    wire         set_nmi = fatal_irq_on_fail_enable_ff && (fire_fail || fire_ok0);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FCS_IDLE:  if (pend_ff && run) nxt_state = FCS_START;
            FCS_START: if (run && dly_ff == 2'(FCS_START_DELAY - 1)) nxt_state = FCS_FETCH;
            FCS_FETCH: if (run && ph_ff == 2'(FCS_FETCH_PERIOD - 1)) nxt_state = FCS_CRC;
            FCS_CRC:   if (run) nxt_state = last_w ? FCS_IDLE : FCS_FETCH;
        endcase
        if (stop_dbg || soft_rst) nxt_state = FCS_IDLE;
        else if (restart && busy_ff && state_ff != FCS_IDLE) nxt_state = FCS_START;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= FCS_IDLE;
            ena_ff <= FCS_CONTROL_A_REGISTER_RST[FCS_BIT_ENABLE];
            fatal_irq_on_fail_enable_ff <= FCS_CONTROL_A_REGISTER_RST[FCS_BIT_FATAL_IRQ_ON_FAIL_ENABLE];
            src_ff <= FCS_CONTROL_B_REGISTER_RST[1:0];
            mode_ff <= FCS_CONTROL_B_REGISTER_RST[5:4];
            busy_ff <= 1'b0;
            ok_ff <= 1'b0;
            nmi_ff <= 1'b0;
            pend_ff <= 1'b0;
            abandon_ff <= 1'b0;
            dly_ff <= 2'h0;
            ph_ff <= 2'h0;
            crc_ff <= FCS_CRC_INIT;
            addr_ff <= '0;
            word_ff <= 16'h0000;
        end else if (ce) begin
            state_ff <= nxt_state;
            abandon_ff <= stop_dbg;
            if (set_nmi) nmi_ff <= 1'b1;
            if (soft_rst) begin
                ena_ff <= 1'b0;
                src_ff <= 2'h0;
                mode_ff <= 2'h0;
                busy_ff <= 1'b0;
                ok_ff <= 1'b0;
                pend_ff <= 1'b0;
            end else begin
                if (wr_a && !busy_ff && pwdata[FCS_BIT_FATAL_IRQ_ON_FAIL_ENABLE]) fatal_irq_on_fail_enable_ff <= 1'b1;
                if (wr_a) ena_ff <= pwdata[FCS_BIT_ENABLE];
                if (wr_b) begin
                    src_ff <= pwdata[FCS_SRC_LSB +: 2];
                    mode_ff <= pwdata[FCS_MODE_LSB +: 2];
                end
                if (go_en || go_dbg) begin
                    busy_ff <= 1'b1;
                    pend_ff <= 1'b1;
                end
                if (wr_s && pwdata[FCS_BIT_OK]) ok_ff <= 1'b1;
                if (fire_ok0) ok_ff <= 1'b0;
                if (stop_dbg) begin
                    busy_ff <= 1'b0;
                    pend_ff <= 1'b0;
                end
                if (state_ff == FCS_IDLE && nxt_state == FCS_START) pend_ff <= 1'b0;
                if (nxt_state == FCS_START && state_ff != FCS_START) begin
                    dly_ff <= 2'h0;
                    crc_ff <= FCS_CRC_INIT;
                    addr_ff <= '0;
                end else if (state_ff == FCS_START && run) begin
                    dly_ff <= dly_ff + 2'h1;
                end
                if (state_ff == FCS_FETCH && run) begin
                    ph_ff <= ph_ff + 2'h1;
                    if (ph_ff == 2'h1) word_ff <= flash_rdata;
                end else if (state_ff != FCS_FETCH) begin
                    ph_ff <= 2'h0;
                end
                if (state_ff == FCS_CRC && run && nxt_state != FCS_START) begin
                    crc_ff <= crc_nx;
                    addr_ff <= addr_ff + AW'(2);
                    if (last_w) begin
                        ok_ff <= pass;
                        busy_ff <= 1'b0;
                    end
                end
            end
        end
    end

    // APB answers in the access cycle; registered outputs lag by nothing visible to the master
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            stall_ff <= 1'b0;
            freq_ff <= 1'b0;
            dbgst_ff <= 2'h0;
        end else if (ce) begin
            pready_ff <= psel && !penable;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    FCS_OFF_CONTROL_A_REGISTER:  prdata_ff <= {30'h0, fatal_irq_on_fail_enable_ff, ena_ff};
                    FCS_OFF_CONTROL_B_REGISTER:  prdata_ff <= {26'h0, mode_ff, 2'h0, src_ff};
                    FCS_OFF_STATUS: prdata_ff <= {30'h0, ok_ff, busy_ff};
                    FCS_OFF_DBGST:  prdata_ff <= {30'h0, ok_ff, busy_ff};
                    default:        prdata_ff <= 32'h0000_0000;
                endcase
            end
            stall_ff <= busy_ff && run && state_ff != FCS_IDLE;
            freq_ff <= nxt_state == FCS_FETCH && state_ff != FCS_FETCH;
            dbgst_ff <= {ok_ff, busy_ff};
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = 1'b0;
    assign flash_req  = freq_ff;
    assign flash_addr = addr_ff;
    assign cpu_stall  = stall_ff;
    assign nmi        = nmi_ff;
    assign dbg_status = dbgst_ff;
    wire unused_ok = mapped ^ abandon_ff;

    property p_nmi_sticky;
        @(posedge clk) disable iff (!nrst) nmi_ff |=> nmi_ff;
    endproperty
    a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi dropped");
    property p_fail_nmi;
        @(posedge clk) disable iff (!nrst) (ce && fire_fail && fatal_irq_on_fail_enable_ff) |=> nmi_ff && !ok_ff;
    endproperty
    a_fail_nmi: assert property (p_fail_nmi) else $error("fail without nmi");
    property p_control_b_register_locked;
        @(posedge clk) disable iff (!nrst) (busy_ff && !soft_rst) |=> $stable(src_ff);
    endproperty
    a_control_b_register_locked: assert property (p_control_b_register_locked) else $error("control_b_register changed busy");
    property p_nowrite_nmi;
        @(posedge clk) disable iff (!nrst) (nmi_ff && !busy_ff) |=> $stable(ena_ff);
    endproperty
    a_nowrite_nmi: assert property (p_nowrite_nmi) else $error("write after nmi");
    property p_start_delay;
        @(posedge clk) disable iff (!nrst)
            (ce && state_ff == FCS_IDLE && nxt_state == FCS_START) ##1 (ce && run)[*3]
            |=> state_ff == FCS_FETCH;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("start delay wrong");
    property p_paused;
        @(posedge clk) disable iff (!nrst)
            (!run && !restart && !stop_dbg && !soft_rst) |=> $stable(crc_ff) && $stable(addr_ff);
    endproperty
    a_paused: assert property (p_paused) else $error("scan moved while held");
    property p_abandon;
        @(posedge clk) disable iff (!nrst) (ce && stop_dbg) |=> !busy_ff && state_ff == FCS_IDLE;
    endproperty
    a_abandon: assert property (p_abandon) else $error("abandon failed");
    property p_done;
        @(posedge clk) disable iff (!nrst)
            (ce && state_ff == FCS_CRC && run && last_w && !restart && !stop_dbg && !soft_rst)
            |=> !busy_ff && ok_ff == $past(pass);
    endproperty
    a_done: assert property (p_done) else $error("completion wrong");
endmodule // fcs_scanner

// [tb/fcs_flash_model.sv]
// Flash model: byte array answering word reads, high byte first.
// Assumes at most one word request per fetch period from the scanner.
`timescale 1ns/10ps
module fcs_flash_model
    import fcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        flash_req,
    input  wire logic [15:0] flash_addr,
    output logic      [15:0] flash_rdata
);
    logic [7:0] mem [0:63];
    int         hold_cnt = 0;
    initial flash_rdata = 16'h0000;
    // Stale data toggles, so sampling after the fetch period shows up
    always @(posedge clk) begin
        if (flash_req === 1'b1) begin
            flash_rdata <= {mem[flash_addr[5:0]], mem[flash_addr[5:0] + 6'h01]};
            hold_cnt    <= FCS_FETCH_PERIOD;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule // fcs_flash_model

// [tb/tb_flash_crc_memory_scanner.sv]
// Testbench for the flash checksum scanner: APB master, flash model, debug pins.
// Assumes the scanner answers APB in one access cycle and reports {ok,busy}.
`timescale 1ns/10ps
module tb_flash_crc_memory_scanner;
    import fcs_pkg::*;
    logic        clk, nrst, psel, penable, pwrite, pready, pdebug, hold, regacc;
    logic        flash_req, stall, nmi;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] boot_end, app_end, flash_end, faddr, frdata, ex;
    logic [1:0]  dbg_status;
    logic [1:0]  srcs [3] = '{2'h1, 2'h0, 2'h2};
    int          ends [3] = '{16, 32, 48};
    int          bad_count, cmp_count, nreq, base;

    fcs_scanner #(.AW(16)) i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(), .pdebug(pdebug), .dbg_hold(hold),
        .dbg_reg_access(regacc), .dbg_disconnect(1'b0), .sleeping(1'b0),
        .boot_end(boot_end), .app_end(app_end), .flash_end(flash_end), .flash_req(flash_req),
        .flash_addr(faddr), .flash_rdata(frdata), .cpu_stall(stall), .nmi(nmi),
        .dbg_status(dbg_status));
    fcs_flash_model i_flash (.clk(clk), .flash_req(flash_req), .flash_addr(faddr),
        .flash_rdata(frdata));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Reference CRC over bytes 0..n-1, msb first
    function automatic logic [15:0] crc_of(int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ i_flash.mem[i][b]) ? 16'h1021 : 16'h0000);
            end
        end
        return c;
    endfunction
    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Look at pready between edges, where it has settled, then close on the next edge
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            check("pready", 1, 0);
            finish_test();
        end
        rd = prdata;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Skip the start delay before polling, busy may rise late
    task automatic run_wait(logic [31:0] control_a_register);
        int n;
        base = nreq;
        if (control_a_register != 0) apb(1, FCS_OFF_CONTROL_A_REGISTER, control_a_register);
        repeat (FCS_START_DELAY + 2) @(posedge clk);
        check("busy", 1, dbg_status[0]);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dbg_status[0] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            check("idle", 1, 0);
            finish_test();
        end
    endtask
    task automatic held(int cyc);
        hold <= 1'b1;
        repeat (cyc) @(posedge clk);
    endtask

    always @(posedge clk) if (flash_req === 1'b1) nreq <= nreq + 1;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, pdebug, hold, regacc} = '0;
        {paddr, pwdata, bad_count, cmp_count, nreq} = '0;
        seed = 32'd41;
        boot_end = 16'h0010;
        app_end = 16'h0020;
        flash_end = 16'h0030;
        for (int i = 0; i < 64; i++) i_flash.mem[i] = 8'(rnd());
        for (int m = 0; m < 3; m++) begin
            ex = crc_of(ends[m] - 2) ^ ((m == 2) ? 16'h0100 : 16'h0000);
            i_flash.mem[ends[m] - 2] = ex[15:8];
            i_flash.mem[ends[m] - 1] = ex[7:0];
        end
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            apb(0, 12'(k * 4), 0);
            check("reset_read", 0, rd);
        end
        for (int m = 0; m < 3; m++) begin
            apb(1, FCS_OFF_CONTROL_B_REGISTER, 32'(srcs[m]));
            run_wait(32'h1);
            check("crc_words", ends[m] / 2, nreq - base);
            apb(0, FCS_OFF_STATUS, 0);
            check("status", (m == 2) ? 0 : 2, rd);
            check("nmi_off", 0, nmi);
        end
        apb(1, FCS_OFF_CONTROL_B_REGISTER, 32'h1);
        apb(1, FCS_OFF_CONTROL_A_REGISTER, 32'h1);
        apb(1, FCS_OFF_CONTROL_B_REGISTER, 32'h2);
        apb(0, FCS_OFF_CONTROL_B_REGISTER, 0);
        check("control_b_register_locked", 1, rd);
        check("stall", 1, stall);
        held(30);
        base = nreq;
        repeat (20) @(posedge clk);
        check("held_req", base, nreq);
        check("held_busy", 1, dbg_status[0]);
        regacc <= 1'b1;
        @(posedge clk);
        regacc <= 1'b0;
        hold <= 1'b0;
        run_wait(0);
        check("restart", 8, nreq - base);
        apb(1, FCS_OFF_CONTROL_A_REGISTER, 32'h1);
        held(10);
        pdebug <= 1'b1;
        apb(1, FCS_OFF_STATUS, 32'h0);
        hold <= 1'b0;
        base = nreq;
        repeat (30) @(posedge clk);
        check("abandon", 0, {nreq - base, dbg_status[0]});
        held(2);
        apb(1, FCS_OFF_STATUS, 32'h1);
        pdebug <= 1'b0;
        hold <= 1'b0;
        run_wait(0);
        check("debug_start", 8, nreq - base);
        apb(1, FCS_OFF_CONTROL_A_REGISTER, 32'h2);
        apb(1, FCS_OFF_CONTROL_B_REGISTER, 32'h2);
        run_wait(32'h3);
        repeat (3) @(posedge clk);
        check("nmi", 1, nmi);
        apb(1, FCS_OFF_CONTROL_B_REGISTER, 32'h1);
        apb(0, FCS_OFF_CONTROL_B_REGISTER, 0);
        check("locked", 2, rd);
        apb(0, FCS_OFF_STATUS, 0);
        check("ok_clear", 0, rd[FCS_BIT_OK]);
        finish_test();
    end
endmodule // tb_flash_crc_memory_scanner
